/* File: design/flash_link_pkg.sv */
// Shared constants for the full-cycle serial flash link.
// Assumes both ends run on one 40 MHz system clock and a bench joins them.
package flash_link_pkg;
	// Host clock divider: half period of the serial clock in system cycles.
	localparam int unsigned sys_period_ns = 25;
	localparam int unsigned sclk_half_ns = 100;
	localparam logic [7:0] sclk_half_cyc =
		8'((sclk_half_ns + sys_period_ns - 1) / sys_period_ns);
	// Pages refreshed per sector and the refresh threshold.
	localparam logic [15:0] pages_per_sector = 16'h0080;
	localparam logic [15:0] refresh_limit = 16'h4e20;
	localparam logic [12:0] page_count = 13'h1fff;
	// Link opcodes; the host bookkeeping uses only op_auto_rewrite.
	localparam logic [7:0] op_page_program = 8'h82;
	localparam logic [7:0] op_buffer_write = 8'h84;
	localparam logic [7:0] op_buffer_program = 8'h83;
	localparam logic [7:0] op_auto_rewrite = 8'h58;
	// Mode seen on select assertion.
	localparam logic mode_0 = 1'b0;
	localparam logic mode_3 = 1'b1;
endpackage : flash_link_pkg

/* File: design/flash_link_if.sv */
// Pins of the serial flash link between host and device.
// Assumes the bench resolves the data-out wire from its enable.
`timescale 1ns/100ps
interface flash_link_if;
	logic sclk;
	logic sel_n;
	logic rst_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	modport host (output sclk, output sel_n, output rst_n, output mosi,
		input miso_o, input miso_oe);
	modport device (input sclk, input sel_n, input rst_n, input mosi,
		output miso_o, output miso_oe);
endinterface : flash_link_if

/* File: design/flash_link_device.sv */
// Device end: byte shifter sampling on rising and driving on falling edges.
// Assumes link pins are asynchronous and sampled through two flip-flops.
`timescale 1ns/100ps
module flash_link_device (
	input wire logic clk_sys,
	input wire logic reset,
	flash_link_if.device link,
	input wire logic [7:0] tx_byte,
	output logic tx_take,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic mode_seen
);
	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] sel_s;
		logic [1:0] mosi_s;
		logic [1:0] rst_s;
		logic [7:0] rx_sh;
		logic [2:0] rx_cnt;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic miso;
		logic oe;
		logic [7:0] rx_out;
		logic rx_v;
		logic take;
		logic mode;
	} dev_s;
	dev_s st_r, st_nxt;
	logic rise, fall, active;

	// Edge detect on the second and third stages only.
	assign rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
	assign fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
	assign active = ~st_r.sel_s[1] & st_r.rst_s[1];

	// Shift logic; a fresh frame reloads the counters.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_s = {st_r.sclk_s[1:0], link.sclk};
		st_nxt.sel_s = {st_r.sel_s[0], link.sel_n};
		st_nxt.mosi_s = {st_r.mosi_s[0], link.mosi};
		st_nxt.rst_s = {st_r.rst_s[0], link.rst_n};
		st_nxt.rx_v = 1'b0;
		st_nxt.take = 1'b0;
		if (!active) begin
			st_nxt.rx_cnt = 3'h0;
			st_nxt.tx_cnt = 3'h0;
			st_nxt.oe = 1'b0;
			st_nxt.mode = st_r.sclk_s[1];
		end else begin
			st_nxt.oe = 1'b1;
			if (rise) begin
				st_nxt.rx_sh = {st_r.rx_sh[6:0], st_r.mosi_s[1]};
				st_nxt.rx_cnt = st_r.rx_cnt + 3'h1;
				if (st_r.rx_cnt == 3'h7) begin
					st_nxt.rx_out = {st_r.rx_sh[6:0], st_r.mosi_s[1]};
					st_nxt.rx_v = 1'b1;
				end
			end
			if (fall) begin
				// Output changes right after the falling edge.
				if (st_r.tx_cnt == 3'h0) begin
					st_nxt.miso = tx_byte[7];
					st_nxt.tx_sh = {tx_byte[6:0], 1'b0};
					st_nxt.take = 1'b1;
				end else begin
					st_nxt.miso = st_r.tx_sh[7];
					st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
				end
				st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
			end
		end
	end

	// State register; synchronous reset to a released output.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_r <= '0;
			st_r.sel_s <= 2'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.miso_o = st_r.miso;
	assign link.miso_oe = st_r.oe;
	assign rx_byte = st_r.rx_out;
	assign rx_valid = st_r.rx_v;
	assign tx_take = st_r.take;
	assign mode_seen = st_r.mode;
endmodule : flash_link_device

/* File: design/flash_link_host.sv */
// Host end: makes the serial clock, launches on rise, captures on fall,
// and keeps the page rewrite pointer and operation count.
// Assumes the user issues one byte at a time and frames with frame_end.
`timescale 1ns/100ps
// Function
// - Device drives on falling, samples on rising.
// - Host captures device bit next falling edge.
// - Host launches its bits on rising edges.
// - Next host bit shifts when device samples.
// - Clock level at select fall gives mode.
// - Compatible variant: output valid during low.
// - General variant: host uses next-fall capture.
// - Select high before device reset release.
// - Rewrite each page within 20000 operations.
// - Rewrite command uses page address pointer.
// - Page written direct or via buffer.
// - Sequential fill repeats per page program.
// - Low power: refresh sector after 20000.
module flash_link_host (
	input wire logic clk_sys,
	input wire logic reset,
	flash_link_if.host link,
	input wire logic idle_high,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic frame_end,
	input wire logic page_op,
	input wire logic lazy_refresh,
	output logic busy,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic refresh_due,
	output logic [12:0] rewrite_page,
	output logic [7:0] rewrite_op
);
	// Boot holds the device in reset, idle parks the clock at its mode
	// level, shift makes the sixteen clock edges of one byte, tail waits
	// out the last full period for the final device bit, and hold keeps
	// select low between bytes of one frame.
	typedef enum logic [4:0] {
		st_boot = 5'b00001,
		st_idle = 5'b00010,
		st_shift = 5'b00100,
		st_tail = 5'b01000,
		st_hold = 5'b10000
	} host_e;
	// All host state lives in one record so that the next value is built
	// in one place. The device answer is taken through two flip-flops,
	// which is why capture always waits a whole clock period: the device
	// changes its pin a few cycles after a falling edge, and the bit only
	// reaches the host one falling edge later.
	typedef struct packed {
		host_e state;
		logic [7:0] div;
		logic sclk;
		logic sel_n;
		logic rst_n;
		logic mosi;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [3:0] edges;
		logic [1:0] miso_s;
		logic [7:0] rx_out;
		logic rx_v;
		logic [15:0] op_cnt;
		logic [12:0] ptr;
		logic [15:0] burst;
	} host_s;
	host_s st_r, st_nxt;
	logic tick;

	assign tick = (st_r.div == flash_link_pkg::sclk_half_cyc - 8'h01);

	// Page pointer step; it wraps over the whole array on purpose.
	function automatic logic [12:0] next_page(input logic [12:0] p);
		next_page = p + 13'h0001;
	endfunction : next_page

	// Host sequencing and refresh bookkeeping.
	always_comb begin
		st_nxt = st_r;
		st_nxt.miso_s = {st_r.miso_s[0], link.miso_o};
		st_nxt.rx_v = 1'b0;
		st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;
		unique case (st_r.state)
			st_boot: begin
				// Select is already high before reset is let go.
				st_nxt.sel_n = 1'b1;
				if (tick) begin
					st_nxt.rst_n = 1'b1;
					st_nxt.state = st_idle;
				end
			end
			st_idle: begin
				st_nxt.sclk = idle_high;
				if (start) begin
					st_nxt.sel_n = 1'b0;
					st_nxt.tx_sh = tx_byte;
					st_nxt.edges = 4'h0;
					st_nxt.div = 8'h00;
					st_nxt.state = st_shift;
				end
			end
			st_shift: if (tick) begin
				st_nxt.sclk = ~st_r.sclk;
				st_nxt.edges = st_r.edges + 4'h1;
				if (!st_r.sclk) begin
					// Rising edge: launch the next bit.
					st_nxt.mosi = st_r.tx_sh[7];
					st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
				end else if (st_r.edges != 4'h0) begin
					// Falling edge: take the bit launched one fall ago.
					st_nxt.rx_sh = {st_r.rx_sh[6:0], st_r.miso_s[1]};
				end
				if (st_r.edges == 4'hf) begin
					// The last device bit was launched on the last
					// falling edge and needs a full period from that edge.
					st_nxt.edges = 4'h0;
					st_nxt.state = st_tail;
				end
			end
			st_tail: if (tick) begin
				// Clock stands still; the capture lands where the next
				// falling edge would be with the clock idle low, or the next rising edge with it idle high. Bits shifted in before the last
				// eight drop out of the word.
				st_nxt.edges = st_r.edges + 4'h1;
				if (st_r.edges == 4'h1) begin
					st_nxt.rx_out = {st_r.rx_sh[6:0], st_r.miso_s[1]};
					st_nxt.rx_v = 1'b1;
					st_nxt.state = st_hold;
				end
			end
			st_hold: begin
				if (frame_end) begin
					st_nxt.sel_n = 1'b1;
					st_nxt.sclk = idle_high;
					st_nxt.state = st_idle;
				end else if (start) begin
					st_nxt.tx_sh = tx_byte;
					st_nxt.edges = 4'h0;
					st_nxt.div = 8'h00;
					st_nxt.state = st_shift;
				end
			end
			default: st_nxt.state = st_boot;
		endcase
		// Each page program, direct or via buffer, counts once.
		if (page_op) begin
			st_nxt.op_cnt = st_r.op_cnt + 16'h0001;
			// The step lands on the last operation of each share, so a
			// full lap of the sector stays inside the limit; stepping
			// one operation later would overrun it.
			if (!lazy_refresh && st_r.op_cnt + 16'h0001 >=
				flash_link_pkg::refresh_limit /
				flash_link_pkg::pages_per_sector) begin
				// Spread rewrites: one pointer step per share.
				st_nxt.op_cnt = 16'h0000;
				st_nxt.ptr = next_page(st_r.ptr);
			end
		end
		// Lazy mode walks a whole sector after the limit.
		if (lazy_refresh && st_r.op_cnt >= flash_link_pkg::refresh_limit &&
			st_r.burst == 16'h0000)
			st_nxt.burst = flash_link_pkg::pages_per_sector;
		if (st_r.burst != 16'h0000 && page_op) begin
			st_nxt.burst = st_r.burst - 16'h0001;
			st_nxt.ptr = next_page(st_r.ptr);
			if (st_r.burst == 16'h0001)
				st_nxt.op_cnt = 16'h0000;
		end
	end

	// State register with synchronous reset; device held in reset.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_r <= '0;
			st_r.state <= st_boot;
			st_r.sel_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.sclk = st_r.sclk;
	assign link.sel_n = st_r.sel_n;
	assign link.rst_n = st_r.rst_n;
	assign link.mosi = st_r.mosi;
	assign busy = (st_r.state != st_idle) && (st_r.state != st_hold);
	assign rx_byte = st_r.rx_out;
	assign rx_valid = st_r.rx_v;
	assign refresh_due = (st_r.burst != 16'h0000) ||
		(st_r.op_cnt >= flash_link_pkg::refresh_limit);
	assign rewrite_page = st_r.ptr;
	assign rewrite_op = flash_link_pkg::op_auto_rewrite;
endmodule : flash_link_host

/* File: tb/flash_link_assertions.sv */
// Checker of the link pins between the host and the device ends.
// Assumes it sits beside the one interface that joins both ends.
`timescale 1ns/100ps
module flash_link_assertions (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic rst_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	// One clock domain, so clock and reset are stated once here.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Releasing the device reset while selected would start a bogus frame.
	sel_before_rst_a: assert property ($rose(rst_n) |-> sel_n)
		else $error("device reset released while selected");
	rst_release_a: assert property ($fell(reset) |->
		sel_n throughout ##[1:8] rst_n)
		else $error("device reset not released while deselected");
	quiet_out_a: assert property (sel_n [*4] |-> !miso_oe)
		else $error("device drives data while deselected");
	oe_follow_a: assert property ($rose(miso_oe) |->
		!sel_n && $past(!sel_n))
		else $error("device drive began without select");
	mosi_launch_a: assert property (!sel_n && $past(!sel_n) &&
		$changed(mosi) |-> $rose(sclk))
		else $error("host data moved off a rising clock edge");
	miso_hold_a: assert property ($rose(sclk) && miso_oe |=>
		$stable(miso_o) [*3])
		else $error("device data moved near a rising clock edge");
	half_period_a: assert property ($changed(sclk) && !sel_n |=>
		$stable(sclk) [*3])
		else $error("serial clock half period is not four cycles");
	sel_edge_a: assert property ($fell(sel_n) |->
		$stable(sclk) [*4])
		else $error("serial clock moved as select fell");
endmodule : flash_link_assertions

/* File: tb/tb_top.sv */
// Bench joining host and device ends through one link interface.
// Assumes a 40 MHz system clock and the design package constants.
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic idle_high = 1'b0;
	logic start = 1'b0;
	logic frame_end = 1'b0;
	logic page_op = 1'b0;
	logic lazy = 1'b0;
	logic [7:0] h_tx = 8'h00;
	logic [7:0] d_tx = 8'h00;
	logic busy, h_rv, mode_seen, due;
	logic [7:0] h_rx, d_rx, op;
	logic [12:0] page;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	// Rows: clock idle level, host byte, device byte.
	localparam logic [16:0] rows [4] = '{17'h0a53c, 17'h000ff,
		17'h1ff00, 17'h1817e};
	// The 25 ns system clock.
	always #12.5 clk_sys = ~clk_sys;
	flash_link_if link ();
	flash_link_host flash_link_host_inst (.clk_sys(clk_sys),
		.reset(reset), .link(link), .idle_high(idle_high),
		.start(start), .tx_byte(h_tx), .frame_end(frame_end),
		.page_op(page_op), .lazy_refresh(lazy), .busy(busy),
		.rx_byte(h_rx), .rx_valid(h_rv), .refresh_due(due),
		.rewrite_page(page), .rewrite_op(op));
	flash_link_device flash_link_device_inst (.clk_sys(clk_sys),
		.reset(reset), .link(link), .tx_byte(d_tx), .tx_take(),
		.rx_byte(d_rx), .rx_valid(), .mode_seen(mode_seen));
	flash_link_assertions flash_link_assertions_inst (.clk_sys(clk_sys),
		.reset(reset), .sclk(link.sclk), .sel_n(link.sel_n),
		.rst_n(link.rst_n), .mosi(link.mosi), .miso_o(link.miso_o),
		.miso_oe(link.miso_oe));
	task automatic close_out();
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(string n, logic [12:0] e, logic [12:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Reset is held three cycles; pins are looked at on both sides of it.
	task automatic do_reset();
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("sel_n", 1'b1, link.sel_n);
		chk("rst_n", 1'b0, link.rst_n);
		reset <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk("rst_n", 1'b1, link.rst_n);
	endtask : do_reset
	// One byte each way; outputs are sampled on the falling edge to
	// stay clear of the rising edge that updates them.
	task automatic xfer(logic [7:0] h, logic [7:0] d);
		int n;
		n = 0;
		h_tx <= h;
		d_tx <= d;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		@(negedge clk_sys);
		while (h_rv !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		chk("host rx", d, h_rx);
		chk("device rx", h, d_rx);
		@(posedge clk_sys);
	endtask : xfer
	task automatic end_frame();
		frame_end <= 1'b1;
		@(posedge clk_sys);
		frame_end <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask : end_frame
	task automatic pulse();
		page_op <= 1'b1;
		@(posedge clk_sys);
		page_op <= 1'b0;
		@(posedge clk_sys);
	endtask : pulse
	// A hang is cut short well beyond the twenty thousand odd cycles needed.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		do_reset();
		foreach (rows[i]) begin
			idle_high <= rows[i][16];
			repeat (12) @(posedge clk_sys);
			chk("mode", rows[i][16], mode_seen);
			xfer(rows[i][15:8], rows[i][7:0]);
			end_frame();
		end
		// Back to back bytes within one frame.
		xfer(8'h5a, 8'hc3);
		xfer(8'h96, 8'h69);
		end_frame();
		// Reset in mid-byte must leave select high before release.
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		repeat (20) @(posedge clk_sys);
		do_reset();
		chk("page", 13'h0000, page);
		repeat (155) pulse();
		chk("page", 13'h0000, page);
		chk("due", 1'b0, due);
		pulse();
		chk("page", 13'h0001, page);
		chk("rewrite op", flash_link_pkg::op_auto_rewrite, op);
		// Low-power refresh: hold off to the limit, then walk a sector.
		lazy <= 1'b1;
		page_op <= 1'b1;
		repeat (19999) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("due", 1'b0, due);
		@(posedge clk_sys);
		page_op <= 1'b0;
		@(negedge clk_sys);
		chk("due", 1'b1, due);
		@(posedge clk_sys);
		repeat (128) pulse();
		chk("page", 13'h0081, page);
		chk("due", 1'b0, due);
		close_out();
	end
endmodule : tb_top
